//--- logic/uar_rx_device.sv
// Receive data recovery with address filter, buffer and local transmitter
// Contract
// - 16 or 8 sample states per bit
// - Three centre samples majority decide bit
// - Receive through first stop bit only
// - Zero first stop sets frame error
// - Next start right after stop vote at normal speed; double speed holds to sample 7 first
// - First vote sample 8 or 4
// - Middle vote sample 9 or 5
// - Far transmitter keeps half rate tolerance
// - Filter drops non-address frames from buffer
// - Transmitter ignores filter bit
// - Frame type from stop or ninth
// - Filtered address frame stored as normal
// - Master uses 9-bit, ninth marks address; remote sender also marks short frames in the first stop bit
// - Slave software manages filter bit
// - Short frames need two stop bits
// - One size setting for both directions
// - No read-modify-write on filter bit
// - Double speed halves samples per bit
// - Writing one clears transmit complete
`timescale 1ns/10ps
`default_nettype none

module uar_fifo #(
	parameter int WIDTH = uar_pkg::FIFO_WIDTH,
	parameter int DEPTH = uar_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// Fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// Drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [CW-1:0]    cnt_q;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready_out = (cnt_q != CW'(DEPTH));
	assign push = in_valid_in && in_ready_out;
	// Output word is a register, so the array feeds it one word ahead
	assign pop = (cnt_q != '0) && (!out_valid_out || out_ready_in);

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= ptr_next(wr_ptr_q);
			end
			if (pop) begin
				rd_ptr_q <= ptr_next(rd_ptr_q);
			end
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else if (pop) begin
			out_valid_out <= 1'b1;
			out_data_out  <= mem_q[rd_ptr_q];
		end else if (out_ready_in) begin
			// Empty head reads zero so no stale flags linger
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end
	end
endmodule // uar_fifo

module uar_rx_device (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Serial link
	uar_link_if.device       link,
	// Configuration
	input  wire logic        double_speed_select_in,
	input  wire logic        multiproc_filter_enable_in,
	input  wire logic        two_stop_bit_select_in,
	input  wire logic [2:0]  character_size_code_in,
	input  wire logic [11:0] baud_divider_value_in,
	// Received frames
	output logic [7:0]       rx_data_out,
	output logic             receive_ninth_bit_out,
	output logic             frame_error_flag_out,
	output logic             rx_valid_out,
	input  wire logic        rx_ready_in,
	output logic             rx_overrun_out,
	// Transmit side
	input  wire logic [7:0]  tx_data_in,
	input  wire logic        transmit_ninth_bit_in,
	input  wire logic        tx_valid_in,
	output logic             tx_ready_out,
	output logic             serial_transmit_pin_out,
	output logic             transmit_complete_flag_out,
	input  wire logic        transmit_complete_clear_in
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_HOLD} uar_rx_state_e;
	typedef enum logic {TX_IDLE, TX_SEND} uar_tx_state_e;

	logic [11:0]   div_q;
	logic          tick_q;
	uar_rx_state_e rx_state_q;
	logic [4:0]    rx_samp_q;
	logic [3:0]    rx_idx_q;
	logic [1:0]    rx_vote_q;
	logic [8:0]    rx_shift_q;
	logic          push_valid_q;
	logic [9:0]    push_data_q;
	logic          fifo_ready;
	logic [9:0]    fifo_word;
	uar_tx_state_e tx_state_q;
	logic [11:0]   tx_vec_q;
	logic [3:0]    tx_left_q;
	logic [4:0]    tx_samp_q;

	logic          line;
	logic          nine;
	logic [3:0]    nbits;
	logic [4:0]    samples_per_bit;
	logic [4:0]    vote_first;
	logic [4:0]    vote_mid;
	logic [4:0]    vote_last;
	logic [4:0]    hold_end;
	logic          voted;
	logic          at_last_vote;
	logic          end_of_bit;
	logic          is_stop;
	logic          frame_type;
	logic          frame_done;
	logic          keep_frame;
	logic [15:0]   tx_frame;
	logic          tx_accept;
	logic          tx_bit_end;
	logic          tx_done;

	assign line  = link.serial_receive_pin;
	assign nine  = (character_size_code_in == uar_pkg::CSZ_NINE);
	assign nbits = uar_pkg::uar_data_bits(character_size_code_in);
	assign samples_per_bit = double_speed_select_in ? uar_pkg::SAMP_DOUBLE
		: uar_pkg::SAMP_NORMAL;
	assign vote_first = double_speed_select_in ? uar_pkg::VOTE_FIRST_DOUBLE
		: uar_pkg::VOTE_FIRST_NORMAL;
	assign vote_mid  = vote_first + uar_pkg::VOTE_MID_OFS;
	assign vote_last = vote_first + uar_pkg::VOTE_LAST_OFS;
	assign hold_end  = vote_first + uar_pkg::HOLD_END_OFS;
	assign voted = uar_pkg::uar_majority(rx_vote_q[1], rx_vote_q[0], line);
	assign at_last_vote = tick_q && (rx_samp_q == vote_last);
	assign end_of_bit   = tick_q && (rx_samp_q == samples_per_bit);
	assign is_stop    = (rx_idx_q == nbits);
	assign frame_done = (rx_state_q == RX_BITS) && at_last_vote && is_stop;
	assign frame_type = nine ? rx_shift_q[8] : voted;
	assign keep_frame = !multiproc_filter_enable_in || frame_type;

	// Sample rate tick; one divider serves both directions
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_q  <= 12'h000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == 12'h000);
			div_q  <= (div_q == 12'h000) ? baud_divider_value_in : div_q - 12'h001;
		end
	end

	// Sample numbering and centre captures
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_samp_q <= uar_pkg::SAMP_FIRST;
			rx_vote_q <= 2'h3;
		end else if (tick_q) begin
			// realign at start; first low sample is 1
			if (rx_state_q == RX_IDLE) begin
				rx_samp_q <= line ? uar_pkg::SAMP_FIRST : uar_pkg::SAMP_FIRST + 5'h01;
			end else if (end_of_bit) begin
				rx_samp_q <= uar_pkg::SAMP_FIRST;
			end else begin
				rx_samp_q <= rx_samp_q + 5'h01;
			end
			if (rx_samp_q == vote_first) begin
				rx_vote_q[1] <= line;
			end
			if (rx_samp_q == vote_mid) begin
				rx_vote_q[0] <= line;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_state_q <= RX_IDLE;
			rx_idx_q   <= 4'h0;
			rx_shift_q <= 9'h000;
		end else if (tick_q) begin
			case (rx_state_q)
				RX_IDLE: begin
					if (!line) begin
						rx_state_q <= RX_START;
					end
				end
				RX_START: begin
					// Majority high means a noise spike, not a start bit
					if (at_last_vote && voted) begin
						rx_state_q <= RX_IDLE;
					end else if (end_of_bit) begin
						rx_state_q <= RX_BITS;
						rx_idx_q   <= 4'h0;
						rx_shift_q <= 9'h000;
					end
				end
				RX_BITS: begin
					if (frame_done) begin
						rx_state_q <= double_speed_select_in ? RX_HOLD : RX_IDLE;
					end else if (at_last_vote) begin
						rx_shift_q[rx_idx_q] <= voted;
					end else if (end_of_bit) begin
						rx_idx_q <= rx_idx_q + 4'h1;
					end
				end
				default: begin
					if (rx_samp_q == hold_end) begin
						rx_state_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// Frames that find the buffer full are lost, flagged by overrun
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			push_valid_q   <= 1'b0;
			push_data_q    <= 10'h000;
			rx_overrun_out <= 1'b0;
		end else begin
			push_valid_q <= frame_done && keep_frame;
			if (frame_done) begin
				push_data_q <= {!voted, nine & rx_shift_q[8], rx_shift_q[7:0]};
			end
			if (push_valid_q) begin
				rx_overrun_out <= !fifo_ready;
			end
		end
	end

	uar_fifo #(
		.WIDTH (uar_pkg::FIFO_WIDTH),
		.DEPTH (uar_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (push_valid_q),
		.in_data_in    (push_data_q),
		.in_ready_out  (fifo_ready),
		.out_valid_out (rx_valid_out),
		.out_data_out  (fifo_word),
		.out_ready_in  (rx_ready_in)
	);

	assign rx_data_out           = fifo_word[7:0];
	assign receive_ninth_bit_out = fifo_word[uar_pkg::NINTH_POS];
	assign frame_error_flag_out  = fifo_word[uar_pkg::FE_POS];

	assign tx_frame = uar_pkg::uar_frame({transmit_ninth_bit_in, tx_data_in},
		character_size_code_in, 1'b1, two_stop_bit_select_in);
	assign tx_accept  = (tx_state_q == TX_IDLE) && tx_valid_in && tx_ready_out;
	assign tx_bit_end = tick_q && (tx_samp_q == samples_per_bit);
	assign tx_done    = (tx_state_q == TX_SEND) && tx_bit_end && (tx_left_q == 4'h1);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_state_q              <= TX_IDLE;
			tx_vec_q                <= 12'hFFF;
			tx_left_q               <= 4'h0;
			tx_samp_q               <= 5'h00;
			tx_ready_out            <= 1'b0;
			serial_transmit_pin_out <= uar_pkg::LINE_IDLE;
		end else if (tx_state_q == TX_IDLE) begin
			tx_ready_out <= !tx_accept;
			if (tx_accept) begin
				tx_state_q              <= TX_SEND;
				tx_vec_q                <= tx_frame[11:0];
				tx_left_q               <= tx_frame[15:12];
				tx_samp_q               <= 5'h00;
				serial_transmit_pin_out <= tx_frame[0];
			end
		end else if (tx_bit_end) begin
			tx_samp_q <= uar_pkg::SAMP_FIRST;
			tx_left_q <= tx_left_q - 4'h1;
			tx_vec_q  <= {1'b1, tx_vec_q[11:1]};
			serial_transmit_pin_out <= tx_done ? uar_pkg::LINE_IDLE : tx_vec_q[1];
			if (tx_done) begin
				tx_state_q   <= TX_IDLE;
				tx_ready_out <= 1'b1;
			end
		end else if (tick_q) begin
			tx_samp_q <= tx_samp_q + 5'h01;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			transmit_complete_flag_out <= 1'b0;
		end else if (tx_done) begin
			transmit_complete_flag_out <= 1'b1;
		end else if (transmit_complete_clear_in) begin
			transmit_complete_flag_out <= 1'b0;
		end
	end
endmodule // uar_rx_device

`default_nettype wire

//--- include/uar_pkg.sv
// Shared constants and helpers for the serial receive recovery link
package uar_pkg;

	// Sample states per bit
	localparam logic [4:0]  SAMP_NORMAL       = 5'h10;
	localparam logic [4:0]  SAMP_DOUBLE       = 5'h08;
	// First voting sample per mode
	localparam logic [4:0]  VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0]  VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0]  VOTE_MID_OFS      = 5'h01;
	localparam logic [4:0]  VOTE_LAST_OFS     = 5'h02;
	localparam logic [4:0]  HOLD_END_OFS      = 5'h03;
	localparam logic [4:0]  SAMP_FIRST        = 5'h01;
	// Character size codes
	localparam logic [2:0]  CSZ_NINE          = 3'h7;
	localparam logic [3:0]  DATA_BITS_MIN     = 4'h5;
	localparam logic [3:0]  DATA_BITS_NINE    = 4'h9;
	localparam logic [3:0]  DATA_BITS_DEFAULT = 4'h8;
	// Reset values
	localparam logic        LINE_IDLE         = 1'b1;
	localparam logic [11:0] BAUD_DIV_DEFAULT  = 12'h004;
	// Receive buffer shape: {frame error, ninth bit, data byte}
	localparam int          FIFO_WIDTH        = 10;
	localparam int          FIFO_DEPTH        = 8;
	localparam int          FE_POS            = 9;
	localparam int          NINTH_POS         = 8;

	// Data bits for a character size code; reserved codes act as 8
	function automatic logic [3:0] uar_data_bits(input logic [2:0] csz);
		if (csz == CSZ_NINE) begin
			return DATA_BITS_NINE;
		end else if (csz[2] == 1'b0) begin
			return DATA_BITS_MIN + {2'h0, csz[1:0]};
		end
		return DATA_BITS_DEFAULT;
	endfunction

	// Two of three wins
	function automatic logic uar_majority(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	// Frame LSB first: start, data, first stop, optional second stop; {len, bits}
	function automatic logic [15:0] uar_frame(input logic [8:0] data, input logic [2:0] csz,
		input logic first_stop, input logic two_stop);
		logic [11:0] vec;
		logic [3:0]  nd;
		logic [3:0]  len;
		vec = 12'hFFF;
		nd = uar_data_bits(csz);
		vec[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < nd) begin
				vec[i + 1] = data[i];
			end
		end
		vec[nd + 4'h1] = first_stop;
		len = nd + 4'h2 + {3'h0, two_stop};
		return {len, vec};
	endfunction

endpackage

//--- include/uar_link_if.sv
// Serial line from the remote transmitter to the receiving device
`timescale 1ns/10ps
`default_nettype none
interface uar_link_if;
	logic serial_receive_pin;
	modport device (input serial_receive_pin);
	modport remote (output serial_receive_pin);
endinterface
`default_nettype wire

//--- logic/uar_remote_tx.sv
// Remote master transmitter driving the serial line with frame type marks
`timescale 1ns/10ps
`default_nettype none

module uar_remote_tx (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Serial link
	uar_link_if.remote       link,
	// Configuration
	input  wire logic        double_speed_select_in,
	input  wire logic        two_stop_bit_select_in,
	input  wire logic [2:0]  character_size_code_in,
	input  wire logic [11:0] baud_divider_value_in,
	// Frames to send
	input  wire logic [7:0]  send_data_in,
	input  wire logic        send_address_in,
	input  wire logic        send_valid_in,
	output logic             send_ready_out,
	output logic             send_done_out
);
	typedef enum logic {TX_IDLE, TX_SEND} uar_remote_state_e;

	uar_remote_state_e state_q;
	logic [11:0]       div_q;
	logic              tick_q;
	logic [11:0]       vec_q;
	logic [3:0]        left_q;
	logic [4:0]        samp_q;
	logic              line_q;

	logic              nine;
	logic              first_stop;
	logic              two_stop;
	logic [4:0]        samples_per_bit;
	logic [15:0]       frame;
	logic              accept;
	logic              bit_end;
	logic              done;

	assign nine = (character_size_code_in == uar_pkg::CSZ_NINE);
	assign first_stop = nine ? 1'b1 : send_address_in;
	assign two_stop   = nine ? two_stop_bit_select_in : 1'b1;
	assign frame = uar_pkg::uar_frame({send_address_in & nine, send_data_in},
		character_size_code_in, first_stop, two_stop);
	assign samples_per_bit = double_speed_select_in ? uar_pkg::SAMP_DOUBLE
		: uar_pkg::SAMP_NORMAL;
	assign accept  = (state_q == TX_IDLE) && send_valid_in && send_ready_out;
	assign bit_end = tick_q && (samp_q == samples_per_bit);
	assign done    = (state_q == TX_SEND) && bit_end && (left_q == 4'h1);
	assign link.serial_receive_pin = line_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_q  <= 12'h000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == 12'h000);
			div_q  <= (div_q == 12'h000) ? baud_divider_value_in : div_q - 12'h001;
		end
	end

	// First bit runs up to one tick long, never short
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q        <= TX_IDLE;
			vec_q          <= 12'hFFF;
			left_q         <= 4'h0;
			samp_q         <= 5'h00;
			send_ready_out <= 1'b0;
			send_done_out  <= 1'b0;
			line_q         <= uar_pkg::LINE_IDLE;
		end else begin
			send_done_out <= done;
			if (state_q == TX_IDLE) begin
				send_ready_out <= !accept;
				if (accept) begin
					state_q <= TX_SEND;
					vec_q   <= frame[11:0];
					left_q  <= frame[15:12];
					samp_q  <= 5'h00;
					line_q  <= frame[0];
				end
			end else if (bit_end) begin
				samp_q <= uar_pkg::SAMP_FIRST;
				left_q <= left_q - 4'h1;
				vec_q  <= {1'b1, vec_q[11:1]};
				line_q <= done ? uar_pkg::LINE_IDLE : vec_q[1];
				if (done) begin
					state_q        <= TX_IDLE;
					send_ready_out <= 1'b1;
				end
			end else if (tick_q) begin
				samp_q <= samp_q + 5'h01;
			end
		end
	end
endmodule // uar_remote_tx

`default_nettype wire

//--- tb/uar_link_monitor.sv
// Checker for the serial link between remote sender and receiving device
`timescale 1ns/10ps
`default_nettype none
module uar_link_monitor (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Link and configuration
	input  wire logic        serial_receive_pin,
	input  wire logic        double_speed_select_in,
	input  wire logic        multiproc_filter_enable_in,
	input  wire logic [2:0]  character_size_code_in,
	input  wire logic [11:0] baud_divider_value_in,
	// Remote request side
	input  wire logic        send_valid_in,
	input  wire logic        send_ready_out,
	input  wire logic        send_done_out,
	// Receive head
	input  wire logic [7:0]  rx_data_out,
	input  wire logic        receive_ninth_bit_out,
	input  wire logic        frame_error_flag_out,
	input  wire logic        rx_valid_out,
	input  wire logic        rx_ready_in
);
	logic [16:0] low_run_q;
	logic [16:0] high_run_q;
	logic [16:0] bit_len;
	logic [4:0]  samp;

	assign samp    = double_speed_select_in ? uar_pkg::SAMP_DOUBLE : uar_pkg::SAMP_NORMAL;
	assign bit_len = 17'(baud_divider_value_in + 12'h001) * {12'h000, samp};

	// Saturating run lengths; reset reads as a long idle
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			low_run_q  <= 17'h00000;
			high_run_q <= 17'h1FFFF;
		end else if (serial_receive_pin) begin
			low_run_q  <= 17'h00000;
			high_run_q <= (high_run_q == 17'h1FFFF) ? high_run_q : high_run_q + 17'h00001;
		end else begin
			high_run_q <= 17'h00000;
			low_run_q  <= (low_run_q == 17'h1FFFF) ? low_run_q : low_run_q + 17'h00001;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	sequence accept_s;
		send_valid_in && send_ready_out;
	endsequence
	sequence done_s;
		send_done_out && send_ready_out && serial_receive_pin;
	endsequence

	start_low_a: assert property (accept_s |=> !serial_receive_pin && !send_ready_out)
		else $error("line not low after accept");
	done_pulse_a: assert property (send_done_out |-> done_s ##1 !send_done_out)
		else $error("send done not a single pulse on idle line");
	low_run_a: assert property ($rose(serial_receive_pin) |-> low_run_q >= bit_len)
		else $error("low level shorter than one bit");
	high_run_a: assert property ($fell(serial_receive_pin) |-> high_run_q >= bit_len)
		else $error("high level shorter than one bit");
	head_stands_a: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out
		&& $stable({rx_data_out, receive_ninth_bit_out, frame_error_flag_out}))
		else $error("receive head changed without pop");
	flags_head_a: assert property (frame_error_flag_out || receive_ninth_bit_out |-> rx_valid_out)
		else $error("frame flags without a head frame");
	filter_ninth_a: assert property ($rose(rx_valid_out) && multiproc_filter_enable_in
		&& character_size_code_in == 3'h7 |-> receive_ninth_bit_out)
		else $error("data frame passed the filter");
	filter_stop_a: assert property ($rose(rx_valid_out) && multiproc_filter_enable_in
		&& character_size_code_in != 3'h7 |-> !frame_error_flag_out)
		else $error("short data frame passed the filter");
	ninth_short_a: assert property (rx_valid_out && character_size_code_in != 3'h7
		|-> !receive_ninth_bit_out)
		else $error("ninth bit set in short format");
endmodule // uar_link_monitor
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for remote sender to receiving device over the link
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_in, nrst_in, ds, filt, two_stop;
	logic [2:0]  csz;
	logic [11:0] baud;
	logic [7:0]  send_data, rx_data, tx_data;
	logic        send_address, send_valid, send_ready, send_done;
	logic        rx_ninth, rx_fe, rx_valid, rx_ready, rx_overrun;
	logic        tx_ninth, tx_valid, tx_ready, tx_pin, tx_flag, tx_clear;
	int          miscompares, num_checks, n, len[2];
	logic [8:0]  exp_q[$];
	logic [2:0]  sizes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};

	uar_link_if link();
	uar_remote_tx u_uar_remote_tx (.clk_in(clk_in), .nrst_in(nrst_in), .link(link),
		.double_speed_select_in(ds), .two_stop_bit_select_in(two_stop),
		.character_size_code_in(csz), .baud_divider_value_in(baud), .send_data_in(send_data),
		.send_address_in(send_address), .send_valid_in(send_valid),
		.send_ready_out(send_ready), .send_done_out(send_done));
	uar_rx_device u_uar_rx_device (.clk_in(clk_in), .nrst_in(nrst_in), .link(link),
		.double_speed_select_in(ds), .multiproc_filter_enable_in(filt),
		.two_stop_bit_select_in(two_stop), .character_size_code_in(csz),
		.baud_divider_value_in(baud), .rx_data_out(rx_data), .receive_ninth_bit_out(rx_ninth),
		.frame_error_flag_out(rx_fe), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
		.rx_overrun_out(rx_overrun), .tx_data_in(tx_data), .transmit_ninth_bit_in(tx_ninth),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .serial_transmit_pin_out(tx_pin),
		.transmit_complete_flag_out(tx_flag), .transmit_complete_clear_in(tx_clear));
	uar_link_monitor u_uar_link_monitor (.clk_in(clk_in), .nrst_in(nrst_in),
		.serial_receive_pin(link.serial_receive_pin), .double_speed_select_in(ds),
		.multiproc_filter_enable_in(filt), .character_size_code_in(csz),
		.baud_divider_value_in(baud), .send_valid_in(send_valid), .send_ready_out(send_ready),
		.send_done_out(send_done), .rx_data_out(rx_data), .receive_ninth_bit_out(rx_ninth),
		.frame_error_flag_out(rx_fe), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	function automatic logic [7:0] exp_data(input logic [7:0] d, input logic [2:0] c);
		int nb;
		nb = (c < 3'h4) ? 5 + int'(c) : 8;
		return d & 8'((9'h001 << nb) - 9'h001);
	endfunction
	function automatic logic exp_line(input logic [8:0] d, input int j);
		logic [10:0] v;
		v = {1'b1, d, 1'b0};
		return v[j];
	endfunction
	function automatic logic exp_fe(input logic a, input logic [2:0] c);
		return (c == 3'h7) ? 1'b0 : !a;
	endfunction

	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic wait_for(ref logic sig);
		int k;
		k = 0;
		while (sig !== 1'b1 && k < 5000) begin
			@(negedge clk_in);
			k++;
		end
		check(sig === 1'b1, "handshake timed out");
	endtask
	task automatic cfg(input logic d, input logic [2:0] c, input logic f);
		ds = d;
		csz = c;
		filt = f;
		baud = 12'($urandom_range(0, 2));
		two_stop = 1'($urandom_range(0, 1));
		// Long idle so the line never shows a gap shorter than the new bit
		repeat (100) @(negedge clk_in);
	endtask
	// Kept frames are those whose type bit is one, or all when unfiltered
	task automatic send(input logic [7:0] d, input logic a);
		wait_for(send_ready);
		send_data = d;
		send_address = a;
		send_valid = 1'b1;
		@(posedge clk_in);
		@(negedge clk_in);
		send_valid = 1'b0;
		if (!filt || a) exp_q.push_back({a, d});
	endtask
	task automatic take();
		logic [8:0] e;
		e = exp_q.pop_front();
		wait_for(rx_valid);
		check(rx_data === exp_data(e[7:0], csz), "rx data mismatch");
		check(rx_ninth === ((csz == 3'h7) ? e[8] : 1'b0), "ninth bit mismatch");
		check(rx_fe === exp_fe(e[8], csz), "frame error mismatch");
		rx_ready = 1'b1;
		@(negedge clk_in);
		rx_ready = 1'b0;
		@(negedge clk_in);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(90000 * 100);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict();
	end

	initial begin
		{nrst_in, ds, filt, two_stop, send_address, send_valid, rx_ready} = 7'h00;
		{tx_ninth, tx_valid, tx_clear} = 3'h0;
		csz = 3'h7;
		baud = 12'h001;
		send_data = 8'h00;
		tx_data = 8'h00;
		miscompares = 0;
		num_checks = 0;
		void'($urandom(32'h6a45));
		repeat (6) @(negedge clk_in);
		nrst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		// Size codes 0 to 3, 5 and 7 in both speeds, back to back frames, corner data
		for (int i = 0; i < 12; i++) begin
			cfg(1'(i / 6), sizes[i % 6], 1'b0);
			send(8'($urandom()), 1'($urandom_range(0, 1)));
			send((i % 2) ? 8'hFF : 8'h00, 1'(i % 2));
			take();
			take();
		end
		$display("test formats done");
		// Filter drops data frames; slave leaves filter after its address
		for (int i = 0; i < 2; i++) begin
			cfg(1'b0, i ? 3'h3 : 3'h7, 1'b1);
			send(8'h5A, 1'b0);
			send(8'($urandom()), 1'b1);
			take();
			filt = 1'b0;
			send(8'hA5, 1'b0);
			take();
			filt = 1'b1;
			send(8'h3C, 1'b0);
			wait_for(send_ready);
			repeat (20) @(negedge clk_in);
			check(rx_valid === 1'b0, "data frame stored while filtered");
		end
		$display("test filter done");
		// Fill the buffer past its nine places, then drain in order
		cfg(1'b0, 3'h7, 1'b0);
		for (int i = 0; i < 10; i++) send(8'($urandom()), 1'($urandom_range(0, 1)));
		void'(exp_q.pop_back());
		wait_for(send_ready);
		repeat (4) @(negedge clk_in);
		check(rx_overrun === 1'b1, "overrun not flagged");
		repeat (9) take();
		check(rx_valid === 1'b0, "buffer not empty after drain");
		send(8'h81, 1'b1);
		take();
		check(rx_overrun === 1'b0, "overrun kept after good store");
		$display("test buffer done");
		// Local sender timing must not depend on the filter bit
		for (int i = 0; i < 2; i++) begin
			cfg(1'b0, 3'h7, 1'(i));
			// Tick every clock so the frame length is exact
			baud = 12'h000;
			two_stop = 1'b0;
			tx_data = 8'hC3;
			tx_ninth = 1'b1;
			repeat (3) @(negedge clk_in);
			wait_for(tx_ready);
			tx_valid = 1'b1;
			@(posedge clk_in);
			@(negedge clk_in);
			tx_valid = 1'b0;
			n = 0;
			while (tx_flag !== 1'b1 && n < 5000) begin
				@(negedge clk_in);
				n++;
				if (n % 16 == 10 && n < 11 * 16) begin
					check(tx_pin === exp_line({tx_ninth, tx_data}, n / 16), "tx bit wrong");
				end
			end
			len[i] = n;
			check(n == 11 * 16 + 1, "local frame length wrong");
			tx_clear = 1'b1;
			@(negedge clk_in);
			tx_clear = 1'b0;
			@(negedge clk_in);
			check(tx_flag === 1'b0, "transmit complete not cleared");
		end
		check(len[0] == len[1], "sender timing depends on filter");
		$display("test local sender done");
		give_verdict();
	end
endmodule // tb
`default_nettype wire
